// >>> hdl/ect_pkg.sv
// shared constants and types of the event triggered countdown timer
`default_nettype none
package ect_pkg;

  // register indices; byte address is four times the index
  localparam logic [5:0] IDX_AUX_STATUS = 6'h05;
  localparam logic [5:0] IDX_IRQ_ENABLE = 6'h06;
  localparam logic [5:0] IDX_IRQ_REQUEST = 6'h07;
  localparam logic [5:0] IDX_CHIP_CONTROL = 6'h09;
  localparam logic [5:0] IDX_COUNT_READBACK = 6'h0C;
  localparam logic [5:0] IDX_CLOCK_CONFIG = 6'h2A;
  localparam logic [5:0] IDX_TRIGGER_CONFIG = 6'h2B;
  localparam logic [5:0] IDX_COUNT_RELOAD = 6'h2C;

  // field positions
  localparam int COUNTING_FLAG_BIT = 7;
  localparam int IRQ_BIT = 5;
  localparam int IMMEDIATE_START_BIT = 1;
  localparam int IMMEDIATE_STOP_BIT = 2;
  localparam int AUTO_RELOAD_BIT = 5;
  localparam int START_TX_FIRST_BIT = 0;
  localparam int START_TX_LAST_BIT = 1;
  localparam int STOP_RX_FIRST_BIT = 2;
  localparam int STOP_RX_LAST_BIT = 3;

  // values after reset
  localparam logic [4:0] EXPONENT_RESET = 5'h00;
  localparam logic [3:0] TRIGGER_RESET = 4'h0;
  localparam logic [7:0] RELOAD_RESET = 8'h00;
  localparam logic [7:0] COUNT_RESET = 8'h00;

  // clock rates and the fractional step that makes the chip clock rate
  localparam int MCLK_PERIOD_PS = 4000;
  localparam int MCLK_KHZ = 1000000000 / MCLK_PERIOD_PS;
  localparam int CHIP_CLOCK_KHZ = 13560;
  localparam int PHASE_WIDTH = 18;
  localparam logic [PHASE_WIDTH-1:0] PHASE_STEP = PHASE_WIDTH'(CHIP_CLOCK_KHZ);
  localparam logic [PHASE_WIDTH-1:0] PHASE_LIMIT = PHASE_WIDTH'(MCLK_KHZ - CHIP_CLOCK_KHZ);
  localparam int MAX_EXPONENT_DEFAULT = 21;

  typedef enum logic {
    ST_IDLE,
    ST_COUNTING
  } ect_state_type;

  typedef enum logic [3:0] {
    SEL_NONE,
    SEL_AUX_STATUS,
    SEL_IRQ_ENABLE,
    SEL_IRQ_REQUEST,
    SEL_CHIP_CONTROL,
    SEL_COUNT_READBACK,
    SEL_CLOCK_CONFIG,
    SEL_TRIGGER_CONFIG,
    SEL_COUNT_RELOAD
  } ect_sel_type;

endpackage : ect_pkg
`default_nettype wire

// >>> hdl/ect_event_sync.sv
// two flip-flop synchroniser with rising edge pulse for timer events
`default_nettype none
module ect_event_sync #(
  parameter int WIDTH = 4
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] eventIn,
  output logic [WIDTH-1:0] eventPulse
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;
  logic [WIDTH-1:0] last_reg;

  if (WIDTH < 1) begin : g_bad_width
    $error("event sync width must be at least one");
  end

  // meta_reg feeds sync_reg only
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      meta_reg <= '0;
      sync_reg <= '0;
      last_reg <= '0;
    end else begin
      meta_reg <= eventIn;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  assign eventPulse = sync_reg & ~last_reg;
endmodule : ect_event_sync
`default_nettype wire

// >>> hdl/ect_prescaler.sv
// timer clock enable: chip clock rate from mclk, divided by a power of two
`default_nettype none
module ect_prescaler #(
  parameter int DIV_WIDTH = 21,
  parameter int EXP_WIDTH = 5
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic restart,
  input wire logic [EXP_WIDTH-1:0] exponent,
  output logic tick
);
  logic [ect_pkg::PHASE_WIDTH-1:0] phase_reg;
  logic [DIV_WIDTH-1:0] div_reg;
  logic [DIV_WIDTH-1:0] mask;
  logic baseTick;
  logic tick_reg;

  if (DIV_WIDTH < 1 || DIV_WIDTH > 31 || ect_pkg::CHIP_CLOCK_KHZ >= ect_pkg::MCLK_KHZ) begin : g_bad_div
    $error("prescaler width or clock rates not supported");
  end

  // average rate is exact; single ticks jitter by one mclk period
  assign baseTick = phase_reg >= ect_pkg::PHASE_LIMIT;
  assign mask = DIV_WIDTH'((DIV_WIDTH'(1) << exponent) - DIV_WIDTH'(1));

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      phase_reg <= '0;
    end else if (restart) begin
      phase_reg <= '0;
    end else if (baseTick) begin
      phase_reg <= phase_reg - ect_pkg::PHASE_LIMIT;
    end else begin
      phase_reg <= phase_reg + ect_pkg::PHASE_STEP;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      div_reg <= '0;
      tick_reg <= 1'b0;
    end else begin
      tick_reg <= baseTick && (div_reg == mask) && !restart;
      if (restart) begin
        div_reg <= '0;
      end else if (baseTick) begin
        div_reg <= (div_reg == mask) ? '0 : div_reg + DIV_WIDTH'(1);
      end
    end
  end

  assign tick = tick_reg;
endmodule : ect_prescaler
`default_nettype wire

// >>> hdl/ect_timer.sv
// event triggered 8-bit countdown timer with apb register slave
//
// Behaviour
// - counter decrements per timer tick while counting and nonzero
// - auto reload: at one, reload instead
// - start on tx first, tx last, software
// - every start without a simultaneous stop reloads counter, retriggering it
// - stop on rx events, zero, software
// - new reload, exponent and auto reload settings apply only at next start
// - software stop never raises interrupt flag
// - tick period two power exponent, max 21
// - start sets counting flag, stop clears it
// - count changes only on timer ticks and starts
// - current count readable at any time
// - reaching zero unstopped raises interrupt flag
// - stop before zero halts without interrupt
// - expiry touches only timer flags
// - auto reload raises interrupt every period
// - flag set on one to zero/reload
// - interrupt output gated by enable bit
`default_nettype none
module ect_timer #(
  parameter int MAX_EXPONENT = ect_pkg::MAX_EXPONENT_DEFAULT
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic txFirstBitEvent,
  input wire logic txLastBitEvent,
  input wire logic rxFirstBitEvent,
  input wire logic rxLastBitEvent,
  output logic countdown_irq_flag,
  output logic countingFlag
);
  if (MAX_EXPONENT < 0 || MAX_EXPONENT > 21) begin : g_bad_exponent
    $error("max exponent must lie in 0..21");
  end

  logic [4:0] exponent_reg;
  logic autoReload_reg;
  logic [3:0] trigger_reg;
  logic [7:0] reload_reg;
  logic irqEnable_reg;
  logic irqFlag_reg;
  logic [7:0] count_reg;
  logic [7:0] count_next;
  ect_pkg::ect_state_type state_reg;
  logic autoRun_reg;
  logic [7:0] reloadRun_reg;
  logic [4:0] exponentRun_reg;
  logic [31:0] prdata_reg;
  logic pslverr_reg;
  logic [3:0] evPulse;
  logic [4:0] exponentLimited;
  logic tick;
  logic running;
  logic swStart;
  logic swStop;
  logic startEv;
  logic stopEv;
  logic expire;
  logic irqClear;
  logic setup;
  logic wrEn;
  ect_pkg::ect_sel_type accSel;
  logic [7:0] rdByte;

  function automatic ect_pkg::ect_sel_type decodeSel(input logic [7:0] addr);
    ect_pkg::ect_sel_type sel;
    sel = ect_pkg::SEL_NONE;
    if (addr[1:0] == 2'b00) begin
      case (addr[7:2])
        ect_pkg::IDX_AUX_STATUS: sel = ect_pkg::SEL_AUX_STATUS;
        ect_pkg::IDX_IRQ_ENABLE: sel = ect_pkg::SEL_IRQ_ENABLE;
        ect_pkg::IDX_IRQ_REQUEST: sel = ect_pkg::SEL_IRQ_REQUEST;
        ect_pkg::IDX_CHIP_CONTROL: sel = ect_pkg::SEL_CHIP_CONTROL;
        ect_pkg::IDX_COUNT_READBACK: sel = ect_pkg::SEL_COUNT_READBACK;
        ect_pkg::IDX_CLOCK_CONFIG: sel = ect_pkg::SEL_CLOCK_CONFIG;
        ect_pkg::IDX_TRIGGER_CONFIG: sel = ect_pkg::SEL_TRIGGER_CONFIG;
        ect_pkg::IDX_COUNT_RELOAD: sel = ect_pkg::SEL_COUNT_RELOAD;
        default: sel = ect_pkg::SEL_NONE;
      endcase
    end
    return sel;
  endfunction : decodeSel

  // event inputs come from other logic timing; edges become one-cycle pulses
  ect_event_sync #(
    .WIDTH(4)
  ) u_sync (
    .mclk(mclk),
    .rst(rst),
    .eventIn({rxLastBitEvent, rxFirstBitEvent, txLastBitEvent, txFirstBitEvent}),
    .eventPulse(evPulse)
  );

  ect_prescaler #(
    .DIV_WIDTH(MAX_EXPONENT + 1),
    .EXP_WIDTH(5)
  ) u_prescaler (
    .mclk(mclk),
    .rst(rst),
    .restart(startEv),
    .exponent(exponentRun_reg),
    .tick(tick)
  );

  // apb: zero wait states, read data captured in the setup cycle
  assign setup = psel && !penable;
  assign wrEn = psel && penable && pwrite;
  assign accSel = decodeSel(paddr);
  assign pready = 1'b1;
  assign prdata = prdata_reg;
  assign pslverr = pslverr_reg;

  // software start and stop exist only in the write cycle
  assign swStart = wrEn && accSel == ect_pkg::SEL_CHIP_CONTROL && pwdata[ect_pkg::IMMEDIATE_START_BIT];
  assign swStop = wrEn && accSel == ect_pkg::SEL_CHIP_CONTROL && pwdata[ect_pkg::IMMEDIATE_STOP_BIT];

  assign running = state_reg == ect_pkg::ST_COUNTING;

  assign startEv = (evPulse[0] && trigger_reg[ect_pkg::START_TX_FIRST_BIT])
    || (evPulse[1] && trigger_reg[ect_pkg::START_TX_LAST_BIT])
    || swStart;

  // stop wins over a start in the same cycle
  assign stopEv = (evPulse[2] && trigger_reg[ect_pkg::STOP_RX_FIRST_BIT])
    || (evPulse[3] && trigger_reg[ect_pkg::STOP_RX_LAST_BIT])
    || swStop;

  // expiry needs no stop or start pending, so a software stop never flags
  assign expire = running && tick && count_reg == 8'h01 && !stopEv && !startEv;

  assign irqClear = wrEn && accSel == ect_pkg::SEL_IRQ_REQUEST && pwdata[ect_pkg::IRQ_BIT];

  // exponents above the supported range are clamped, not wrapped
  assign exponentLimited = (exponent_reg > 5'(MAX_EXPONENT)) ? 5'(MAX_EXPONENT) : exponent_reg;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      exponent_reg <= ect_pkg::EXPONENT_RESET;
      autoReload_reg <= 1'b0;
      trigger_reg <= ect_pkg::TRIGGER_RESET;
      reload_reg <= ect_pkg::RELOAD_RESET;
      irqEnable_reg <= 1'b0;
    end else if (wrEn) begin
      unique case (accSel)
        ect_pkg::SEL_CLOCK_CONFIG: begin
          exponent_reg <= pwdata[4:0];
          autoReload_reg <= pwdata[ect_pkg::AUTO_RELOAD_BIT];
        end
        ect_pkg::SEL_TRIGGER_CONFIG: begin
          trigger_reg <= pwdata[3:0];
        end
        ect_pkg::SEL_COUNT_RELOAD: begin
          reload_reg <= pwdata[7:0];
        end
        ect_pkg::SEL_IRQ_ENABLE: begin
          irqEnable_reg <= pwdata[ect_pkg::IRQ_BIT];
        end
        ect_pkg::SEL_NONE, ect_pkg::SEL_AUX_STATUS, ect_pkg::SEL_IRQ_REQUEST,
        ect_pkg::SEL_CHIP_CONTROL, ect_pkg::SEL_COUNT_READBACK: begin
        end
      endcase
    end
  end

  // settings are copied at start so later writes leave a running count alone
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      autoRun_reg <= 1'b0;
      reloadRun_reg <= ect_pkg::RELOAD_RESET;
      exponentRun_reg <= ect_pkg::EXPONENT_RESET;
    end else if (startEv && !stopEv) begin
      autoRun_reg <= autoReload_reg;
      reloadRun_reg <= reload_reg;
      exponentRun_reg <= exponentLimited;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_reg <= ect_pkg::ST_IDLE;
    end else begin
      unique case (state_reg)
        ect_pkg::ST_IDLE: begin
          if (startEv && !stopEv) begin
            state_reg <= ect_pkg::ST_COUNTING;
          end
        end
        ect_pkg::ST_COUNTING: begin
          if (stopEv) begin
            state_reg <= ect_pkg::ST_IDLE;
          end else if (!startEv && tick && !autoRun_reg && count_reg <= 8'h01) begin
            state_reg <= ect_pkg::ST_IDLE;
          end
        end
      endcase
    end
  end

  always_comb begin
    count_next = count_reg;
    if (stopEv) begin
      count_next = count_reg;
    end else if (startEv) begin
      count_next = reload_reg;
    end else if (running && tick) begin
      if (count_reg == 8'h01 && autoRun_reg) begin
        count_next = reloadRun_reg;
      end else if (count_reg != 8'h00) begin
        count_next = count_reg - 8'h01;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      count_reg <= ect_pkg::COUNT_RESET;
    end else begin
      count_reg <= count_next;
    end
  end

  // expiry drives only this flag; nothing reaches transmit or receive
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      irqFlag_reg <= 1'b0;
    end else if (expire) begin
      irqFlag_reg <= 1'b1;
    end else if (irqClear) begin
      irqFlag_reg <= 1'b0;
    end
  end

  assign countdown_irq_flag = irqFlag_reg && irqEnable_reg;
  assign countingFlag = running;

  always_comb begin
    rdByte = 8'h00;
    unique case (accSel)
      ect_pkg::SEL_AUX_STATUS: rdByte[ect_pkg::COUNTING_FLAG_BIT] = running;
      ect_pkg::SEL_IRQ_ENABLE: rdByte[ect_pkg::IRQ_BIT] = irqEnable_reg;
      ect_pkg::SEL_IRQ_REQUEST: rdByte[ect_pkg::IRQ_BIT] = irqFlag_reg;
      ect_pkg::SEL_COUNT_READBACK: rdByte = count_reg;
      ect_pkg::SEL_CLOCK_CONFIG: rdByte = {2'b00, autoReload_reg, exponent_reg};
      ect_pkg::SEL_TRIGGER_CONFIG: rdByte = {4'h0, trigger_reg};
      ect_pkg::SEL_COUNT_RELOAD: rdByte = reload_reg;
      ect_pkg::SEL_NONE, ect_pkg::SEL_CHIP_CONTROL: rdByte = 8'h00;
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      prdata_reg <= 32'h00000000;
      pslverr_reg <= 1'b0;
    end else if (setup) begin
      prdata_reg <= {24'h000000, rdByte};
      pslverr_reg <= accSel == ect_pkg::SEL_NONE;
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  a_count_decrements: assert property (
    running && tick && count_reg > 8'h01 && !startEv && !stopEv
      |=> count_reg == $past(count_reg) - 8'h01 && running)
    else $error("count did not decrement on tick");

  a_auto_reload_hit: assert property (
    running && tick && count_reg == 8'h01 && autoRun_reg && !startEv && !stopEv
      |=> running && count_reg == reloadRun_reg && count_reg != 8'h00)
    else $error("auto reload did not reload at one");

  a_start_loads_count: assert property (
    startEv && !stopEv |=> running && count_reg == $past(reload_reg))
    else $error("start did not load reload value");

  a_stop_clears_run: assert property (
    stopEv |=> !running && $stable(count_reg))
    else $error("stop did not clear counting flag");

  a_soft_stop_noirq: assert property (
    swStop && !irqFlag_reg |=> !irqFlag_reg)
    else $error("software stop raised interrupt flag");

  a_expiry_flags: assert property (
    running && tick && count_reg == 8'h01 && !startEv && !stopEv
      |=> irqFlag_reg && (running == $past(autoRun_reg)))
    else $error("expiry did not flag or stop correctly");

  a_hold_off_tick: assert property (
    !tick && !startEv |=> $stable(count_reg))
    else $error("count changed without a tick");

  // only the cycle after the write is judged; a later start may load new settings
  a_config_no_effect: assert property (
    running && wrEn && (accSel == ect_pkg::SEL_COUNT_RELOAD || accSel == ect_pkg::SEL_CLOCK_CONFIG) && !startEv
      |=> $stable(reloadRun_reg) && $stable(autoRun_reg) && $stable(exponentRun_reg))
    else $error("config write disturbed running count");

  a_irq_gated: assert property (
    countdown_irq_flag |-> irqEnable_reg && irqFlag_reg)
    else $error("interrupt output without enable");

  a_idle_frozen: assert property (
    !running && !startEv |=> $stable(count_reg) && !expire)
    else $error("idle timer moved");

  a_oneshot_ends: assert property (
    running && tick && count_reg == 8'h01 && !autoRun_reg && !startEv && !stopEv
      |=> !running && count_reg == 8'h00)
    else $error("one shot did not end at zero");

  a_stop_no_flag: assert property (
    stopEv && !irqFlag_reg |=> !irqFlag_reg)
    else $error("stop event raised interrupt flag");

  a_stop_priority: assert property (
    swStart && swStop |=> !running && $stable(count_reg))
    else $error("start won over a simultaneous stop");

  a_flag_clear: assert property (
    irqClear && !expire |=> !irqFlag_reg)
    else $error("interrupt flag did not clear");

  a_flag_on_tick: assert property (
    $rose(irqFlag_reg) |-> $past(tick) && $past(running) && $past(count_reg) == 8'h01)
    else $error("interrupt flag rose without a tick at one");

  a_readback_live: assert property (
    setup && accSel == ect_pkg::SEL_COUNT_READBACK |=> prdata == {24'h000000, $past(count_reg)})
    else $error("count readback did not show the live count");

  // the fractional step is far below the limit, so ticks never come back to back
  a_tick_gap: assert property (
    tick |=> !tick)
    else $error("timer ticks on consecutive cycles");
endmodule : ect_timer
`default_nettype wire

// >>> test/ect_timer_tb_top.sv
// self-checking bench of the event triggered countdown timer
`default_nettype none
module ect_timer_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [34:0] ALL = {35{1'b1}};
  localparam logic [34:0] NO_IRQ = ALL & ~(35'h1 << 33);
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [3:0] ev = 4'h0;
  logic countdown_irq_flag;
  logic countingFlag;
  integer seed = 32'h5723;
  logic [7:0] rnd;
  int miscompares = 0;
  int total_checks = 0;
  logic [34:0] expQ[$];
  logic [34:0] maskQ[$];
  logic [34:0] exp1;
  logic [34:0] msk1;

  ect_timer uut (
    .mclk(mclk),
    .rst(rst),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .txFirstBitEvent(ev[0]),
    .txLastBitEvent(ev[1]),
    .rxFirstBitEvent(ev[2]),
    .rxLastBitEvent(ev[3]),
    .countdown_irq_flag(countdown_irq_flag),
    .countingFlag(countingFlag)
  );

  initial begin
    forever #2 mclk = ~mclk;
  end

  function automatic logic [7:0] ad(input logic [5:0] i);
    return {i, 2'b00};
  endfunction : ad

  function automatic logic [34:0] ex(input logic cf, input logic irq, input logic err, input logic [7:0] v);
    return {cf, irq, err, 24'h0, v};
  endfunction : ex

  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : conclude

  task automatic compare(input logic [34:0] got, input logic [34:0] want, input logic [34:0] m);
    total_checks++;
    if ((got & m) !== (want & m)) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got & m, want & m);
    end
  endtask : compare

  // bus cycle: hold the request until pready is seen high at an edge
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1 && n < 100) begin
      @(posedge mclk);
      n++;
    end
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 100) begin
      miscompares++;
      $display("MISMATCH t=%0t pready=%h exp=%h", $time, pready, 1'b1);
      conclude();
    end
  endtask : xfer

  task automatic wr(input logic [5:0] i, input logic [7:0] d);
    xfer(ad(i), 1'b1, {24'h0, d});
  endtask : wr

  // expectation is queued before the bus cycle that produces it
  task automatic rd(input logic [7:0] a, input logic [34:0] e, input logic [34:0] m = ALL);
    expQ.push_back(e);
    maskQ.push_back(m);
    xfer(a, 1'b0, 32'h0);
  endtask : rd

  // waits for a level; bounded so a dead timer cannot hang the run
  task automatic waitFor(input logic onIrq, input logic level);
    int n;
    n = 0;
    // always let one edge pass: a level seen in the edge's own time step may be stale
    do begin
      @(posedge mclk);
      #1;
      n++;
    end while (((onIrq ? countdown_irq_flag : countingFlag) !== level) && n < 2000);
    total_checks++;
    if (n >= 2000) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, ~level, level);
      conclude();
    end
  endtask : waitFor

  // event held well past the synchroniser, then low long enough to re-arm
  task automatic pulse(input int b);
    @(posedge mclk);
    ev[b] <= 1'b1;
    repeat (3) @(posedge mclk);
    ev[b] <= 1'b0;
    repeat (6) @(posedge mclk);
  endtask : pulse

  always @(posedge mclk) begin
    if (psel && penable && pready && !pwrite) begin
      exp1 = expQ.pop_front();
      msk1 = maskQ.pop_front();
      compare({countingFlag, countdown_irq_flag, pslverr, prdata}, exp1, msk1);
    end
  end

  initial begin
    logic [5:0] regs[8];
    regs = '{ect_pkg::IDX_AUX_STATUS, ect_pkg::IDX_IRQ_ENABLE, ect_pkg::IDX_IRQ_REQUEST, ect_pkg::IDX_CHIP_CONTROL,
             ect_pkg::IDX_COUNT_READBACK, ect_pkg::IDX_CLOCK_CONFIG, ect_pkg::IDX_TRIGGER_CONFIG,
             ect_pkg::IDX_COUNT_RELOAD};
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    foreach (regs[i]) rd(ad(regs[i]), ex(1'b0, 1'b0, 1'b0, 8'h00));
    rd(8'h00, ex(1'b0, 1'b0, 1'b1, 8'h00));
    rd(8'hB1, ex(1'b0, 1'b0, 1'b1, 8'h00));
    repeat (4) begin
      rnd = 8'($random(seed));
      wr(ect_pkg::IDX_COUNT_RELOAD, rnd);
      rd(ad(ect_pkg::IDX_COUNT_RELOAD), ex(1'b0, 1'b0, 1'b0, rnd));
      wr(ect_pkg::IDX_TRIGGER_CONFIG, rnd);
      rd(ad(ect_pkg::IDX_TRIGGER_CONFIG), ex(1'b0, 1'b0, 1'b0, {4'h0, rnd[3:0]}));
      wr(ect_pkg::IDX_CLOCK_CONFIG, {2'b00, rnd[5], 5'(rnd[4:0] % 22)});
      rd(ad(ect_pkg::IDX_CLOCK_CONFIG), ex(1'b0, 1'b0, 1'b0, {2'b00, rnd[5], 5'(rnd[4:0] % 22)}));
      wr(ect_pkg::IDX_COUNT_READBACK, rnd);
      rd(ad(ect_pkg::IDX_COUNT_READBACK), ex(1'b0, 1'b0, 1'b0, 8'h00));
    end
    // one shot from the fastest clock
    wr(ect_pkg::IDX_IRQ_ENABLE, 8'h20);
    wr(ect_pkg::IDX_CLOCK_CONFIG, 8'h00);
    wr(ect_pkg::IDX_TRIGGER_CONFIG, 8'h00);
    wr(ect_pkg::IDX_COUNT_RELOAD, 8'h03);
    wr(ect_pkg::IDX_CHIP_CONTROL, 8'h02);
    rd(ad(ect_pkg::IDX_AUX_STATUS), ex(1'b1, 1'b0, 1'b0, 8'h80));
    rd(ad(ect_pkg::IDX_COUNT_READBACK), ex(1'b1, 1'b0, 1'b0, 8'h03));
    waitFor(1'b0, 1'b0);
    rd(ad(ect_pkg::IDX_COUNT_READBACK), ex(1'b0, 1'b1, 1'b0, 8'h00));
    rd(ad(ect_pkg::IDX_IRQ_REQUEST), ex(1'b0, 1'b1, 1'b0, 8'h20));
    wr(ect_pkg::IDX_IRQ_ENABLE, 8'h00);
    rd(ad(ect_pkg::IDX_IRQ_REQUEST), ex(1'b0, 1'b0, 1'b0, 8'h20));
    wr(ect_pkg::IDX_IRQ_REQUEST, 8'h20);
    wr(ect_pkg::IDX_IRQ_ENABLE, 8'h20);
    rd(ad(ect_pkg::IDX_IRQ_REQUEST), ex(1'b0, 1'b0, 1'b0, 8'h00));
    // slowest clock keeps the count frozen, so values are exact
    wr(ect_pkg::IDX_CLOCK_CONFIG, 8'h15);
    wr(ect_pkg::IDX_COUNT_RELOAD, 8'hC8);
    wr(ect_pkg::IDX_CHIP_CONTROL, 8'h02);
    wr(ect_pkg::IDX_COUNT_RELOAD, 8'h05);
    wr(ect_pkg::IDX_CLOCK_CONFIG, 8'h20);
    rd(ad(ect_pkg::IDX_COUNT_READBACK), ex(1'b1, 1'b0, 1'b0, 8'hC8));
    wr(ect_pkg::IDX_CLOCK_CONFIG, 8'h15);
    wr(ect_pkg::IDX_CHIP_CONTROL, 8'h02);
    rd(ad(ect_pkg::IDX_COUNT_READBACK), ex(1'b1, 1'b0, 1'b0, 8'h05));
    wr(ect_pkg::IDX_CHIP_CONTROL, 8'h04);
    rd(ad(ect_pkg::IDX_IRQ_REQUEST), ex(1'b0, 1'b0, 1'b0, 8'h00));
    // both bits while running: the stop must win
    wr(ect_pkg::IDX_CHIP_CONTROL, 8'h02);
    rd(ad(ect_pkg::IDX_AUX_STATUS), ex(1'b1, 1'b0, 1'b0, 8'h80));
    wr(ect_pkg::IDX_CHIP_CONTROL, 8'h06);
    rd(ad(ect_pkg::IDX_AUX_STATUS), ex(1'b0, 1'b0, 1'b0, 8'h00));
    // hardware events: disabled ones must be ignored
    for (int i = 0; i < 2; i++) begin
      wr(ect_pkg::IDX_TRIGGER_CONFIG, (i == 1) ? 8'h0A : 8'h05);
      pulse(1 - i);
      rd(ad(ect_pkg::IDX_AUX_STATUS), ex(1'b0, 1'b0, 1'b0, 8'h00));
      pulse(i);
      rd(ad(ect_pkg::IDX_AUX_STATUS), ex(1'b1, 1'b0, 1'b0, 8'h80));
      pulse(3 - i);
      rd(ad(ect_pkg::IDX_AUX_STATUS), ex(1'b1, 1'b0, 1'b0, 8'h80));
      pulse(i + 2);
      rd(ad(ect_pkg::IDX_AUX_STATUS), ex(1'b0, 1'b0, 1'b0, 8'h00));
      rd(ad(ect_pkg::IDX_IRQ_REQUEST), ex(1'b0, 1'b0, 1'b0, 8'h00));
      // no tick at the slowest clock: reload minus held count gives zero elapsed
      rd(ad(ect_pkg::IDX_COUNT_READBACK), ex(1'b0, 1'b0, 1'b0, 8'h05));
    end
    // periodic trigger never stops by itself
    wr(ect_pkg::IDX_TRIGGER_CONFIG, 8'h00);
    wr(ect_pkg::IDX_COUNT_RELOAD, 8'h02);
    wr(ect_pkg::IDX_CLOCK_CONFIG, 8'h20);
    wr(ect_pkg::IDX_CHIP_CONTROL, 8'h02);
    repeat (3) begin
      waitFor(1'b1, 1'b1);
      rd(ad(ect_pkg::IDX_AUX_STATUS), ex(1'b1, 1'b0, 1'b0, 8'h80), NO_IRQ);
      wr(ect_pkg::IDX_IRQ_REQUEST, 8'h20);
    end
    wr(ect_pkg::IDX_CHIP_CONTROL, 8'h04);
    rd(ad(ect_pkg::IDX_AUX_STATUS), ex(1'b0, 1'b0, 1'b0, 8'h00), NO_IRQ);
    conclude();
  end
endmodule : ect_timer_tb_top
`default_nettype wire
